// ### core/dstn_defs.svh
`ifndef DSTN_DEFS_SVH
`define DSTN_DEFS_SVH

// register offsets
`define OFS_DEVICE_IDENTITY   8'h00
`define OFS_SILICON_REVISION  8'h01
`define OFS_PANEL_CONTROL     8'h02
`define OFS_BLOCK_SELECT      8'h03

// memory windows: top address bits and their match value
`define DITHER_WIN_TAG        3'h4
`define FRAME_WIN_TAG         2'h3

// control byte fields
`define CTRL_SOFT_RESET       7
`define CTRL_PANEL_ENABLE     6
`define CTRL_REFRESH_2X       5
`define CTRL_MAP_HI           4
`define CTRL_MAP_LO           3
`define CTRL_MOD_MODIFIED     2
`define CTRL_PANEL_24BIT      1
`define CTRL_PASS_THROUGH     0

// reset values
`define PANEL_CONTROL_RST     8'h00
`define BLOCK_SELECT_RST      2'h0

// memory sizes in bytes
`define FRAME_BYTES           256
`define DITHER_BYTES          32

`endif

// ### core/dstn_pkg.sv
package dstn_pkg;

  // colour memory routing selected by control bits 4:3
  typedef enum logic [1:0] {
    MAP_ALL,
    MAP_RED,
    MAP_GREEN,
    MAP_BLUE
  } map_sel_t;

  // one serial byte
  typedef logic [7:0] byte_t;

endpackage

// ### core/colour_memory.sv
`timescale 1ns/1ps
`default_nettype none
`include "dstn_defs.svh"

module colour_memory (
  input  wire logic        clk,
  input  wire logic        ce,
  input  wire logic        wr_en,
  input  wire logic        sel_frame,
  input  wire logic [7:0]  byte_index,
  input  wire logic [7:0]  wdata,
  output logic      [7:0]  rdata,
  input  wire logic [10:0] frame_bit_addr,
  input  wire logic [7:0]  dither_bit_addr,
  output logic             frame_bit,
  output logic             dither_bit
);

  ////////////////////////////////////////////////////////////////////////////
  // storage: byte arrays in flip-flops
  ////////////////////////////////////////////////////////////////////////////
  logic [7:0] frame_mem  [`FRAME_BYTES];   // 64 frames x 32 levels
  logic [7:0] dither_mem [`DITHER_BYTES];  // 16 patterns of 4x4

  // bit offset zero sits in the msb of a byte, as sent first
  function automatic logic pick_bit(input logic [7:0] b,
                                    input logic [2:0] ofs);
    pick_bit = b[3'h7 - ofs];
  endfunction

  // byte read for the serial window
  assign rdata = sel_frame ? frame_mem[byte_index]
                         : dither_mem[byte_index[4:0]];

  // byte write from the serial window
  always_ff @(posedge clk) begin
    if (ce && wr_en) begin
      if (sel_frame) begin
        frame_mem[byte_index] <= wdata;
      end else begin
        dither_mem[byte_index[4:0]] <= wdata;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // pixel path lookups, registered
  ////////////////////////////////////////////////////////////////////////////
  always_ff @(posedge clk) begin
    if (ce) begin
      frame_bit  <= pick_bit(frame_mem[frame_bit_addr[10:3]],
                             frame_bit_addr[2:0]);
      dither_bit <= pick_bit(dither_mem[dither_bit_addr[7:3]],
                             dither_bit_addr[2:0]);
    end
  end

endmodule

`default_nettype wire

// ### core/dstn_control_register_bank.sv
`timescale 1ns/1ps
`default_nettype none
`include "dstn_defs.svh"

module dstn_control_register_bank #(
  parameter logic [7:0] DEVICE_IDENTITY  = 8'h5a,  // arbitrary value
  parameter logic [7:0] SILICON_REVISION = 8'h01   // arbitrary value
) (
  input  wire logic        SYS_CLK,
  input  wire logic        RESET_N,
  input  wire logic        CLK_EN,
  // byte access port from the serial programming front end
  input  wire logic        ACC_VALID,
  input  wire logic        ACC_WRITE,
  input  wire logic [7:0]  ACC_ADDR,
  input  wire logic [7:0]  ACC_WDATA,
  output logic             ACC_RVALID,
  output logic      [7:0]  ACC_RDATA,
  // external panel power request pin
  input  wire logic        PANEL_POWER_REQUEST_IN,
  // pixel path lookups into the colour memories
  input  wire logic [10:0] FRAME_MOD_BIT_ADDR,
  input  wire logic [7:0]  DITHER_BIT_ADDR,
  output logic      [2:0]  FRAME_MOD_BITS,
  output logic      [2:0]  DITHER_BITS,
  // control outputs
  output logic             SOFT_RESET_OUT,
  output logic             PANEL_ON,
  output logic             REFRESH_2X,
  output logic             MOD_MODIFIED,
  output logic             PANEL_24BIT,
  output logic             PASS_THROUGH
);

  ////////////////////////////////////////////////////////////////////////////
  // state
  ////////////////////////////////////////////////////////////////////////////
  logic [7:0] ctrl_ff;          // control byte
  logic [1:0] blk_ff;           // modulation block select
  logic       soft_rst_ff;      // soft reset in progress
  logic       pwr_s1_ff;        // power request sync stage 1
  logic       pwr_s2_ff;        // sync stage 2
  logic       pwr_s3_ff;        // sync stage 3
  logic       pwr_ff;           // filtered power request
  logic [7:0] rdata_ff;         // read answer
  logic       rvalid_ff;        // read answer strobe
  logic       panel_on_ff;      // panel enable output
  logic       r2x_ff;           // refresh mode output
  logic       mod_ff;           // modulation mode output
  logic       p24_ff;           // panel width output
  logic       pass_ff;          // pass-through output

  ////////////////////////////////////////////////////////////////////////////
  // address decode
  ////////////////////////////////////////////////////////////////////////////
  wire        is_id    = (ACC_ADDR == `OFS_DEVICE_IDENTITY);
  wire        is_rev   = (ACC_ADDR == `OFS_SILICON_REVISION);
  wire        is_ctrl  = (ACC_ADDR == `OFS_PANEL_CONTROL);
  wire        is_blk   = (ACC_ADDR == `OFS_BLOCK_SELECT);
  wire        is_dith  = (ACC_ADDR[7:5] == `DITHER_WIN_TAG);
  wire        is_frame = (ACC_ADDR[7:6] == `FRAME_WIN_TAG);
  wire        is_mem   = is_dith | is_frame;
  wire        locked   = ctrl_ff[`CTRL_PANEL_ENABLE];
  wire        wr       = ACC_VALID & ACC_WRITE & ~soft_rst_ff;
  wire        rd       = ACC_VALID & ~ACC_WRITE;

  // control and block select stay writable while locked
  wire        wr_ctrl  = wr & is_ctrl;
  wire        wr_blk   = wr & is_blk;
  wire        sr_req   = wr_ctrl & ACC_WDATA[`CTRL_SOFT_RESET];

  ////////////////////////////////////////////////////////////////////////////
  // colour memory routing
  ////////////////////////////////////////////////////////////////////////////
  dstn_pkg::map_sel_t map_sel;
  assign map_sel = dstn_pkg::map_sel_t'(
    ctrl_ff[`CTRL_MAP_HI:`CTRL_MAP_LO]);

  // memory writes dropped while locked
  wire        mem_wr   = wr & is_mem & ~locked;

  // broadcast write in map-all, else a single colour
  wire [2:0]  col_wr_sel = (map_sel == dstn_pkg::MAP_ALL)   ? 3'h7 :
                           (map_sel == dstn_pkg::MAP_RED)   ? 3'h1 :
                           (map_sel == dstn_pkg::MAP_GREEN) ? 3'h2 :
                                                              3'h4;
  // map-all reads the red memory
  wire [1:0]  col_rd_idx = (map_sel == dstn_pkg::MAP_GREEN) ? 2'h1 :
                           (map_sel == dstn_pkg::MAP_BLUE)  ? 2'h2 :
                                                              2'h0;

  // frame table byte index: block number above the window offset
  wire [7:0]  mem_index = is_frame ? {blk_ff, ACC_ADDR[5:0]}
                                   : {3'h0, ACC_ADDR[4:0]};

  dstn_pkg::byte_t col_rdata [3];

  genvar c;
  generate
    for (c = 0; c < 3; c++) begin : g_colour
      // one memory pair per colour
      colour_memory u_mem (
        .clk             (SYS_CLK),
        .ce              (CLK_EN),
        .wr_en           (mem_wr & col_wr_sel[c]),
        .sel_frame       (is_frame),
        .byte_index      (mem_index),
        .wdata           (ACC_WDATA),
        .rdata           (col_rdata[c]),
        .frame_bit_addr  (FRAME_MOD_BIT_ADDR),
        .dither_bit_addr (DITHER_BIT_ADDR),
        .frame_bit       (FRAME_MOD_BITS[c]),
        .dither_bit      (DITHER_BITS[c])
      );
    end
  endgenerate

  ////////////////////////////////////////////////////////////////////////////
  // read data select
  ////////////////////////////////////////////////////////////////////////////
  wire [7:0]  mem_rd    = locked ? 8'h00 : col_rdata[col_rd_idx];
  wire [7:0]  nxt_rdata = is_id   ? DEVICE_IDENTITY :
                          is_rev  ? SILICON_REVISION :
                          is_ctrl ? ctrl_ff :
                          is_blk  ? {6'h00, blk_ff} :
                          is_mem  ? mem_rd :
                                    8'h00;

  // next control byte: soft reset returns it to zero
  wire [7:0]  nxt_ctrl  = soft_rst_ff ? `PANEL_CONTROL_RST :
                          wr_ctrl     ? ACC_WDATA : ctrl_ff;
  wire [1:0]  nxt_blk   = soft_rst_ff ? `BLOCK_SELECT_RST :
                          wr_blk      ? ACC_WDATA[1:0] : blk_ff;

  ////////////////////////////////////////////////////////////////////////////
  // registers and soft reset
  ////////////////////////////////////////////////////////////////////////////
  always_ff @(posedge SYS_CLK or negedge RESET_N) begin
    if (!RESET_N) begin
      ctrl_ff     <= `PANEL_CONTROL_RST;
      blk_ff      <= `BLOCK_SELECT_RST;
      soft_rst_ff <= 1'b0;
    end else if (CLK_EN) begin
      ctrl_ff     <= nxt_ctrl;
      blk_ff      <= nxt_blk;
      soft_rst_ff <= sr_req;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // read answer, one cycle after the request
  ////////////////////////////////////////////////////////////////////////////
  always_ff @(posedge SYS_CLK or negedge RESET_N) begin
    if (!RESET_N) begin
      rdata_ff  <= 8'h00;
      rvalid_ff <= 1'b0;
    end else if (CLK_EN) begin
      rvalid_ff <= rd;
      if (rd) begin
        rdata_ff <= nxt_rdata;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // power request pin synchroniser and filter
  ////////////////////////////////////////////////////////////////////////////
  always_ff @(posedge SYS_CLK or negedge RESET_N) begin
    if (!RESET_N) begin
      pwr_s1_ff <= 1'b0;
      pwr_s2_ff <= 1'b0;
      pwr_s3_ff <= 1'b0;
      pwr_ff    <= 1'b0;
    end else if (CLK_EN) begin
      pwr_s1_ff <= PANEL_POWER_REQUEST_IN;
      pwr_s2_ff <= pwr_s1_ff;
      pwr_s3_ff <= pwr_s2_ff;
      // accept a change once stages two and three agree
      if (pwr_s2_ff == pwr_s3_ff) begin
        pwr_ff <= pwr_s3_ff;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // mode outputs
  ////////////////////////////////////////////////////////////////////////////
  wire nxt_panel = ctrl_ff[`CTRL_PANEL_ENABLE] & pwr_ff;
  wire nxt_r2x   = ctrl_ff[`CTRL_REFRESH_2X];
  wire nxt_mod   = ctrl_ff[`CTRL_MOD_MODIFIED];
  wire nxt_pass  = ctrl_ff[`CTRL_PASS_THROUGH];
  wire nxt_p24   = ctrl_ff[`CTRL_PANEL_24BIT] & ~nxt_pass;

  always_ff @(posedge SYS_CLK or negedge RESET_N) begin
    if (!RESET_N) begin
      panel_on_ff <= 1'b0;
      r2x_ff      <= 1'b0;
      mod_ff      <= 1'b0;
      p24_ff      <= 1'b0;
      pass_ff     <= 1'b0;
    end else if (CLK_EN) begin
      panel_on_ff <= nxt_panel;
      r2x_ff      <= nxt_r2x;
      mod_ff      <= nxt_mod;
      p24_ff      <= nxt_p24;
      pass_ff     <= nxt_pass;
    end
  end

  // output drive
  assign ACC_RDATA      = rdata_ff;
  assign ACC_RVALID     = rvalid_ff;
  assign SOFT_RESET_OUT = soft_rst_ff;
  assign PANEL_ON       = panel_on_ff;
  assign REFRESH_2X     = r2x_ff;
  assign MOD_MODIFIED   = mod_ff;
  assign PANEL_24BIT    = p24_ff;
  assign PASS_THROUGH   = pass_ff;

endmodule

`default_nettype wire

// ### verification/reg_bank_assertions.sv
`timescale 1ns/1ps
`default_nettype none
module reg_bank_assertions (
  input wire logic       SYS_CLK,
  input wire logic       RESET_N,
  input wire logic       CLK_EN,
  input wire logic       ACC_VALID,
  input wire logic       ACC_WRITE,
  input wire logic [7:0] ACC_ADDR,
  input wire logic [7:0] ACC_WDATA,
  input wire logic       ACC_RVALID,
  input wire logic [7:0] ACC_RDATA,
  input wire logic       SOFT_RESET_OUT,
  input wire logic       PANEL_ON,
  input wire logic       REFRESH_2X,
  input wire logic       MOD_MODIFIED,
  input wire logic       PANEL_24BIT,
  input wire logic       PASS_THROUGH
);
  default clocking @(posedge SYS_CLK); endclocking
  default disable iff (!RESET_N);
  ////////////////////////////////////////////////////////////////////////////
  // control byte write that is taken, not the dead cycle after soft reset
  sequence ctrl_wr_s;
    CLK_EN && ACC_VALID && ACC_WRITE && ACC_ADDR == 8'h02 && !SOFT_RESET_OUT;
  endsequence
  // control write without the soft reset bit
  sequence mode_wr_s;
    ctrl_wr_s ##0 !ACC_WDATA[7];
  endsequence
  a_read_answer: assert property (
    CLK_EN && ACC_VALID && !ACC_WRITE |=> ACC_RVALID)
    else $error("read not answered");
  // a frozen cycle keeps the strobe as it was, so only running cycles count
  a_no_stray_answer: assert property (
    CLK_EN && !(ACC_VALID && !ACC_WRITE) |=> !ACC_RVALID)
    else $error("answer without read");
  a_rdata_hold: assert property (
    !ACC_RVALID |-> $stable(ACC_RDATA))
    else $error("read data moved");
  a_soft_reset_pulse: assert property (
    ctrl_wr_s ##0 ACC_WDATA[7] |=> SOFT_RESET_OUT ##1 !SOFT_RESET_OUT)
    else $error("soft reset pulse wrong");
  a_soft_reset_cause: assert property (
    SOFT_RESET_OUT |-> $past(ACC_VALID && ACC_WRITE &&
                             ACC_ADDR == 8'h02 && ACC_WDATA[7]))
    else $error("soft reset without cause");
  a_refresh_mode: assert property (
    mode_wr_s |=> ##1 REFRESH_2X == $past(ACC_WDATA[5], 2))
    else $error("refresh mode wrong");
  a_mod_select: assert property (
    mode_wr_s |=> ##1 MOD_MODIFIED == $past(ACC_WDATA[2], 2))
    else $error("modulation mode wrong");
  a_pass_override: assert property (
    mode_wr_s |=> ##1 PASS_THROUGH == $past(ACC_WDATA[0], 2) &&
    PANEL_24BIT == ($past(ACC_WDATA[1], 2) && !$past(ACC_WDATA[0], 2)))
    else $error("panel format wrong");
  a_panel_off: assert property (
    ctrl_wr_s ##0 !ACC_WDATA[6] |=> ##1 !PANEL_ON)
    else $error("panel on while disabled");
endmodule
bind dstn_control_register_bank reg_bank_assertions u_chk (
  .SYS_CLK(SYS_CLK), .RESET_N(RESET_N), .CLK_EN(CLK_EN),
  .ACC_VALID(ACC_VALID), .ACC_WRITE(ACC_WRITE), .ACC_ADDR(ACC_ADDR),
  .ACC_WDATA(ACC_WDATA), .ACC_RVALID(ACC_RVALID), .ACC_RDATA(ACC_RDATA),
  .SOFT_RESET_OUT(SOFT_RESET_OUT), .PANEL_ON(PANEL_ON),
  .REFRESH_2X(REFRESH_2X), .MOD_MODIFIED(MOD_MODIFIED),
  .PANEL_24BIT(PANEL_24BIT), .PASS_THROUGH(PASS_THROUGH));
`default_nettype wire

// ### verification/host_model.sv
`timescale 1ns/1ps
`default_nettype none
module host_model (
  input  wire logic       clk,
  input  wire logic       rvalid,
  input  wire logic [7:0] rdata,
  output logic            valid,
  output logic            write,
  output logic      [7:0] addr,
  output logic      [7:0] wdata
);
  initial begin
    valid = 0; write = 0; addr = 8'h00; wdata = 8'h00;
  end
  // one byte per access, held over one taking edge, then released
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge clk); #1;
    valid = 1; write = 1; addr = a; wdata = d;
    @(posedge clk); #1;
    valid = 0; addr = ~addr; wdata = ~wdata; // released bus shows junk
  endtask
  // read waits a bounded time for the answer, unknown on timeout
  task automatic rd(input logic [7:0] a, output logic [7:0] d);
    @(posedge clk); #1;
    valid = 1; write = 0; addr = a;
    @(posedge clk); #1;
    valid = 0; addr = ~addr;
    d = 8'hxx;
    for (int n = 0; n < 4; n++) begin
      if (rvalid === 1'b1) begin
        d = rdata;
        break;
      end
      @(posedge clk); #1;
    end
  endtask
endmodule
`default_nettype wire

// ### verification/dstn_control_register_bank_tb.sv
`timescale 1ns/1ps
`default_nettype none
module dstn_control_register_bank_tb;
  logic        sys_clk = 0;      // free-running clock
  logic        reset_n = 0;      // hardware reset, low at start
  logic        ce      = 1;      // clock enable
  logic        pwr     = 0;      // panel power request pin
  logic        rv, sro, pon;     // read strobe, soft reset, panel on
  logic        r2x, mm, p24, pt; // mode outputs
  logic        v, w;             // access valid and write
  logic [7:0]  a, wd, rdat, d;   // address, data, answer, read value
  logic [7:0]  md;               // mode outputs packed for a compare
  logic [10:0] fma = 11'h000;    // frame table lookup address
  logic [7:0]  dit = 8'h00;      // dither lookup address
  logic [2:0]  fb, db;           // lookup bits per colour
  int          err_total = 0;
  int          samples_checked = 0;
  // ctrl value, then expected {2x, modified, 24bit, pass}
  logic [11:0] rows [6] = '{12'h208, 12'h044, 12'h022,
                            12'h031, 12'h180, 12'h27d};
  always #2 sys_clk = ~sys_clk;
  host_model host (.clk(sys_clk), .rvalid(rv), .rdata(rdat), .valid(v),
    .write(w), .addr(a), .wdata(wd));
  dstn_control_register_bank dut (.SYS_CLK(sys_clk), .RESET_N(reset_n),
    .CLK_EN(ce), .ACC_VALID(v), .ACC_WRITE(w), .ACC_ADDR(a),
    .ACC_WDATA(wd), .ACC_RVALID(rv), .ACC_RDATA(rdat),
    .PANEL_POWER_REQUEST_IN(pwr), .FRAME_MOD_BIT_ADDR(fma),
    .DITHER_BIT_ADDR(dit), .FRAME_MOD_BITS(fb), .DITHER_BITS(db),
    .SOFT_RESET_OUT(sro), .PANEL_ON(pon), .REFRESH_2X(r2x),
    .MOD_MODIFIED(mm), .PANEL_24BIT(p24), .PASS_THROUGH(pt));
  task automatic check(input string what, input logic [7:0] seen,
                       input logic [7:0] exp);
    samples_checked++;
    if (seen !== exp) begin
      err_total++;
      $display("mismatch %s expected %h seen %h", what, exp, seen);
    end
  endtask
  task automatic rchk(input logic [7:0] ad, input logic [7:0] exp);
    host.rd(ad, d);
    check("read", d, exp);
  endtask
  task automatic look(input logic [10:0] f, input logic [7:0] di,
                      input logic [2:0] ef, input logic [2:0] ed);
    fma = f;
    dit = di;
    @(posedge sys_clk); #1;
    check("lookup", {2'b00, fb, db}, {2'b00, ef, ed});
  endtask
  task automatic test_done;
    $display("checks %0d mismatches %0d", samples_checked, err_total);
    if (err_total == 0 && samples_checked > 0) $display("ALL CHECKS OK");
    else $display("CHECKS NOT OK");
    $finish;
  endtask
  ////////////////////////////////////////////////////////////////////////////
  // watchdog
  initial begin
    repeat (5000) @(posedge sys_clk);
    err_total++;
    test_done();
  end
  // main sequence
  initial begin
    repeat (3) @(posedge sys_clk);
    #1 reset_n = 1;
    check("reset outs", {2'b00, sro, pon, r2x, mm, p24, pt}, 8'h00);
    rchk(8'h02, 8'h00);
    // a write offered while the clock enable is low must not land
    ce = 0;
    host.wr(8'h02, 8'h20);
    ce = 1;
    rchk(8'h02, 8'h00);
    check("frozen", {7'h00, r2x}, 8'h00);
    foreach (rows[i]) begin
      host.wr(8'h02, rows[i][11:4]);
      @(posedge sys_clk); #1;
      md = {4'h0, r2x, mm, p24, pt};
      check("modes", md, 8'(rows[i][3:0]));
    end
    host.wr(8'h00, 8'hff);
    rchk(8'h00, 8'h5a);
    rchk(8'h01, 8'h01);
    // memories first, enable last
    host.wr(8'h02, 8'h00);
    host.wr(8'h80, 8'ha5);
    host.wr(8'h81, 8'h5a);
    host.wr(8'h02, 8'h10);
    host.wr(8'h81, 8'h3c);
    for (int m = 0; m < 4; m++) begin
      host.wr(8'h02, 8'(m << 3));
      rchk(8'h80, 8'ha5);
      rchk(8'h81, (m == 2) ? 8'h3c : 8'h5a);
    end
    // map-all again, so that all three frame tables are filled
    host.wr(8'h02, 8'h00);
    host.wr(8'h03, 8'h00);
    host.wr(8'hc0, 8'h11);
    host.wr(8'h03, 8'h01);
    host.wr(8'hc0, 8'h22);
    rchk(8'h03, 8'h01);
    rchk(8'hc0, 8'h22);
    host.wr(8'h03, 8'h00);
    rchk(8'hc0, 8'h11);
    look(11'h000, 8'h00, 3'b000, 3'b111);
    look(11'h000, 8'h09, 3'b000, 3'b101);
    look(11'h003, 8'h00, 3'b111, 3'b111);
    look(11'h202, 8'h00, 3'b111, 3'b111);
    host.wr(8'h02, 8'h40);
    host.wr(8'h80, 8'hff);
    host.wr(8'hc0, 8'hff);
    rchk(8'h80, 8'h00);
    host.wr(8'h03, 8'h02);
    rchk(8'h03, 8'h02);
    check("panel on", {7'h00, pon}, 8'h00);
    pwr = 1;
    repeat (6) @(posedge sys_clk);
    #1 check("panel on", {7'h00, pon}, 8'h01);
    host.wr(8'h02, 8'h00);
    rchk(8'h80, 8'ha5);
    check("panel on", {7'h00, pon}, 8'h00);
    host.wr(8'h03, 8'h00);
    rchk(8'hc0, 8'h11);
    // leave a non-zero block select for the soft reset to clear
    host.wr(8'h03, 8'h03);
    host.wr(8'h02, 8'ha1);
    check("soft reset", {7'h00, sro}, 8'h01);
    rchk(8'h02, 8'h00);
    rchk(8'h03, 8'h00);
    // hardware reset in mid-run clears the mode outputs at once
    host.wr(8'h02, 8'h20);
    @(posedge sys_clk); #1;
    check("refresh", {7'h00, r2x}, 8'h01);
    reset_n = 0;
    @(posedge sys_clk); #1;
    reset_n = 1;
    check("reset outs", {2'b00, sro, pon, r2x, mm, p24, pt}, 8'h00);
    rchk(8'h02, 8'h00);
    test_done();
  end
endmodule
`default_nettype wire
